// file: dutc_pkg.sv
// Shared constants, layouts and helpers for the converter channel update and toggle control
package dutc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH     = 96;
  localparam int NUM_SUB    = 4;
  localparam int CH_PER_SUB = 24;
  localparam int CODE_W     = 12;
  localparam int DATA_W     = 16;
  localparam int SLOT_W     = 5;
  localparam int SUB_W      = 2;
  localparam int DIV_W      = 3;
  localparam int CNT_W      = 6;
  localparam int ADDR_W     = 6;
  localparam int CH_IDX_W   = 7;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_BUF_A = 4'h0;
  localparam logic [3:0] IDX_BUF_B = 4'h1;
  localparam logic [3:0] IDX_CTL   = 4'h4;
  localparam logic [3:0] IDX_SEL   = 4'h6;
  localparam logic [3:0] IDX_DIV   = 4'h9;

  // ----------------------------------------------------------------
  // Field positions, reset values and encodings
  // ----------------------------------------------------------------
  localparam int              BUF_LSB    = 4;
  localparam int              SUB_LSB    = 12;
  localparam int              SLOT_LSB   = 0;
  localparam int              LOAD_BIT   = 15;
  localparam logic [15:0]     CTL_RESET  = 16'h0555;
  localparam logic [15:0]     CTL_WMASK  = 16'h0ff3;
  localparam logic [1:0]      FIELD_ON   = 2'h2;
  localparam logic [DIV_W-1:0] DIV_MAX   = 3'h6;
  localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;
  localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [CODE_W-1:0] CODE_MIN  = 12'h800;
  localparam logic [CODE_W-1:0] CODE_MAX  = 12'h7ff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       load;
    logic [2:0] rsv_hi;
    logic [1:0] rd_rate;
    logic [1:0] drive;
    logic [1:0] rd_edge;
    logic [1:0] clr;
    logic       rsv_lo;
    logic       fixed_one;
    logic [1:0] autoneg;
  } dutc_ctl_t;

  typedef struct packed {
    logic load_strobe_n;
    logic clear_n;
    logic trigger;
  } dutc_pins_t;

  localparam dutc_pins_t PINS_RESET = '{load_strobe_n: 1'b1, clear_n: 1'b1, trigger: 1'b0};

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [CODE_W-1:0] neg_sat(input logic [CODE_W-1:0] v);
    if (v == CODE_MIN) begin
      return CODE_MAX;
    end
    return (~v) + 12'h001;
  endfunction : neg_sat

  function automatic logic [CH_IDX_W-1:0] chan_idx(input logic [SUB_W-1:0] sub,
                                                   input logic [SLOT_W-1:0] slot);
    return ({5'h00, sub} * 7'h18) + {2'h0, slot};
  endfunction : chan_idx

endpackage : dutc_pkg

// file: dutc_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module dutc_pin_sync #(
  parameter int              WIDTH = 3,
  parameter logic [WIDTH-1:0] RST  = '0
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Pins and result
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
    end else if (ce) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Only the later stages are compared, never the metastable first one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= RST;
    end else if (ce) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          pin_out[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule : dutc_pin_sync

// file: dutc_ind_div.sv
// Divider that flips the active register indicator once every two-to-the-N toggle pulses
`timescale 1ns/100ps
module dutc_ind_div (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      ce,
  // Control
  input  wire logic                      pulse,
  input  wire logic [dutc_pkg::DIV_W-1:0] div,
  // Result
  output logic                           ind
);

  logic [dutc_pkg::CNT_W-1:0] cnt_reg;
  logic [dutc_pkg::CNT_W-1:0] limit;

  assign limit = dutc_pkg::CNT_W'((7'h01 << div) - 7'h01);

  // ----------------------------------------------------------------
  // Pulse counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      ind     <= 1'b0;
    end else if (ce && pulse) begin
      if (cnt_reg >= limit) begin
        cnt_reg <= '0;
        ind     <= ~ind;
      end else begin
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

endmodule : dutc_ind_div

// file: dutc_top.sv
// APB-controlled update, clear and toggle logic for the bank of converter channels
// What this block does
// - Channel codes are 12-bit two's complement, -2048 to 2047, zero gives zero.
// - After reset every channel data register holds zero.
// - Every channel has an A and a B data register.
// - Writes land in a buffer; outputs change only after transfer to active.
// - Reads of data registers return the buffered value.
// - Load strobe low: a data write goes straight to active and output.
// - Load strobe high: writes wait for a load event.
// - Load strobe falling edge moves all 96 buffers to active together.
// - Self-clearing load bit updates all channels of the selected subsystem.
// - Clear shows zero but keeps contents; leaving clear reloads outputs.
// - Data writes are still taken during clear.
// - Clear pin low clears all 96 channels; high restores them.
// - Subsystem clear field clears only that subsystem.
// - Trigger rising edge arms toggling; each later falling edge swaps A/B.
// - Auto-negate on: a write to A loads B with minus the value, -2048 giving 2047.
// - A direct write to B never changes A.
// - With N = 0, indicator low while A is active, high while B is active.
// - Indicator undriven after reset; driven only by subsystem 0 drive field.
// - Indicator flips once every 2^N pulses, N limited to 0..6.
// - Fixed trigger means one register drives; A until an armed falling edge.
// - Data and control register accesses affect only the subsystem chosen by the pointer.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
module dutc_top (
  // Clock, reset and enable
  input  wire logic                                            pclk,
  input  wire logic                                            presetn,
  input  wire logic                                            ce,
  // APB slave
  input  wire logic                                            psel,
  input  wire logic                                            penable,
  input  wire logic                                            pwrite,
  input  wire logic [dutc_pkg::ADDR_W-1:0]                     paddr,
  input  wire logic [31:0]                                     pwdata,
  output logic      [31:0]                                     prdata,
  output logic                                                 pready,
  output logic                                                 pslverr,
  // Control pins
  input  wire logic                                            load_strobe_n,
  input  wire logic                                            clear_n,
  input  wire logic                                            toggle_trigger_pin,
  // Channel codes and indicator
  output logic      [dutc_pkg::NUM_CH*dutc_pkg::CODE_W-1:0]    dac_code_out,
  output logic                                                 active_reg_indicator,
  output logic                                                 active_reg_indicator_oe
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [dutc_pkg::CODE_W-1:0] buf_a_mem [dutc_pkg::NUM_CH];
  logic [dutc_pkg::CODE_W-1:0] buf_b_mem [dutc_pkg::NUM_CH];
  logic [dutc_pkg::CODE_W-1:0] act_a_mem [dutc_pkg::NUM_CH];
  logic [dutc_pkg::CODE_W-1:0] act_b_mem [dutc_pkg::NUM_CH];

  dutc_pkg::dutc_ctl_t          ctl_reg [dutc_pkg::NUM_SUB];
  logic [dutc_pkg::SUB_W-1:0]   sub_reg;
  logic [dutc_pkg::SLOT_W-1:0]  slot_reg;
  logic [dutc_pkg::DIV_W-1:0]   div_reg;
  logic                         ack_reg;
  logic [31:0]                  prdata_reg;
  logic                         pslverr_reg;
  dutc_pkg::dutc_pins_t         pins_s;
  dutc_pkg::dutc_pins_t         pins_d_reg;
  logic                         armed_reg;
  logic                         sel_b_reg;
  logic                         ind_oe_reg;
  logic                         ind_raw;

  // ----------------------------------------------------------------
  // Pin synchronisation and edges
  // ----------------------------------------------------------------
  dutc_pin_sync #(
    .WIDTH (3),
    .RST   (dutc_pkg::PINS_RESET)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pin_in  ({load_strobe_n, clear_n, toggle_trigger_pin}),
    .pin_out (pins_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_d_reg <= dutc_pkg::PINS_RESET;
    end else if (ce) begin
      pins_d_reg <= pins_s;
    end
  end

  logic load_fall;
  logic trig_rise;
  logic trig_fall;
  logic async_mode;
  logic tog_pulse;

  assign load_fall  = pins_d_reg.load_strobe_n && !pins_s.load_strobe_n;
  assign trig_rise  = !pins_d_reg.trigger && pins_s.trigger;
  assign trig_fall  = pins_d_reg.trigger && !pins_s.trigger;
  assign async_mode = !pins_s.load_strobe_n;
  assign tog_pulse  = trig_fall && armed_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic                          setup;
  logic                          access;
  logic                          wr;
  logic [3:0]                    idx;
  logic                          aligned;
  logic                          hit_a;
  logic                          hit_b;
  logic                          hit_ctl;
  logic                          hit_sel;
  logic                          hit_div;
  logic                          ch_ok;
  logic [dutc_pkg::CH_IDX_W-1:0] ch;
  logic [dutc_pkg::CODE_W-1:0]   wcode;
  logic [dutc_pkg::CODE_W-1:0]   wneg;
  logic                          neg_on;
  logic                          wr_a;
  logic                          wr_b;
  logic                          wr_ctl;

  assign setup   = psel && !penable && ce;
  assign pready  = psel && penable && ack_reg && ce;
  assign access  = pready;
  assign wr      = access && pwrite;
  assign idx     = paddr[5:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign ch      = dutc_pkg::chan_idx(sub_reg, slot_reg);
  assign ch_ok   = (slot_reg < 5'(dutc_pkg::CH_PER_SUB));
  assign hit_a   = aligned && (idx == dutc_pkg::IDX_BUF_A) && ch_ok;
  assign hit_b   = aligned && (idx == dutc_pkg::IDX_BUF_B) && ch_ok;
  assign hit_ctl = aligned && (idx == dutc_pkg::IDX_CTL);
  assign hit_sel = aligned && (idx == dutc_pkg::IDX_SEL);
  assign hit_div = aligned && (idx == dutc_pkg::IDX_DIV);
  assign wcode   = pwdata[dutc_pkg::BUF_LSB +: dutc_pkg::CODE_W];
  assign wneg    = dutc_pkg::neg_sat(wcode);
  assign neg_on  = (ctl_reg[sub_reg].autoneg == dutc_pkg::FIELD_ON);
  assign wr_a    = wr && hit_a;
  assign wr_b    = wr && hit_b;
  assign wr_ctl  = wr && hit_ctl;

  // Answer is prepared in the setup cycle so the access phase never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
    end else if (ce) begin
      ack_reg <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      pslverr_reg <= !(hit_a || hit_b || hit_ctl || hit_sel || hit_div);
      prdata_reg  <= 32'h0000_0000;
      if (!pwrite) begin
        if (hit_a) begin
          prdata_reg <= {16'h0000, buf_a_mem[ch], 4'h0};
        end else if (hit_b) begin
          prdata_reg <= {16'h0000, buf_b_mem[ch], 4'h0};
        end else if (hit_ctl) begin
          prdata_reg <= {16'h0000, ctl_reg[sub_reg] & (dutc_pkg::CTL_RESET | dutc_pkg::CTL_WMASK)};
        end else if (hit_sel) begin
          prdata_reg <= {18'h00000, sub_reg, 7'h00, slot_reg};
        end else if (hit_div) begin
          prdata_reg <= {29'h00000000, div_reg};
        end
      end
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // ----------------------------------------------------------------
  // Pointer, control and divider registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_reg  <= '0;
      slot_reg <= '0;
    end else if (ce && wr && hit_sel) begin
      sub_reg  <= pwdata[dutc_pkg::SUB_LSB +: dutc_pkg::SUB_W];
      slot_reg <= pwdata[dutc_pkg::SLOT_LSB +: dutc_pkg::SLOT_W];
    end
  end

  // Load bit is never stored, so it always reads back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < dutc_pkg::NUM_SUB; s++) begin
        ctl_reg[s] <= dutc_pkg::CTL_RESET;
      end
    end else if (ce && wr_ctl) begin
      ctl_reg[sub_reg] <= (pwdata[15:0] & dutc_pkg::CTL_WMASK) | (dutc_pkg::CTL_RESET & ~dutc_pkg::CTL_WMASK);
    end
  end

  // Values above the limit saturate instead of wrapping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= dutc_pkg::DIV_RESET;
    end else if (ce && wr && hit_div) begin
      if (pwdata[15:0] > {13'h0000, dutc_pkg::DIV_MAX}) begin
        div_reg <= dutc_pkg::DIV_MAX;
      end else begin
        div_reg <= pwdata[dutc_pkg::DIV_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffer registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < dutc_pkg::NUM_CH; i++) begin
        buf_a_mem[i] <= dutc_pkg::CODE_ZERO;
        buf_b_mem[i] <= dutc_pkg::CODE_ZERO;
      end
    end else if (ce) begin
      if (wr_a) begin
        buf_a_mem[ch] <= wcode;
      end
      if (wr_b) begin
        buf_b_mem[ch] <= wcode;
      end else if (wr_a && neg_on) begin
        buf_b_mem[ch] <= wneg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Active registers
  // ----------------------------------------------------------------
  logic [dutc_pkg::NUM_SUB-1:0] load_sub;
  logic [dutc_pkg::NUM_SUB-1:0] clear_sub;

  always_comb begin
    load_sub  = '0;
    clear_sub = '0;
    for (int s = 0; s < dutc_pkg::NUM_SUB; s++) begin
      load_sub[s]  = wr_ctl && pwdata[dutc_pkg::LOAD_BIT] && (sub_reg == 2'(s));
      clear_sub[s] = (ctl_reg[s].clr == dutc_pkg::FIELD_ON);
    end
  end

  // A write in the same cycle as a strobe falling edge still reaches active, as the strobe is already low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < dutc_pkg::NUM_CH; i++) begin
        act_a_mem[i] <= dutc_pkg::CODE_ZERO;
        act_b_mem[i] <= dutc_pkg::CODE_ZERO;
      end
    end else if (ce) begin
      for (int i = 0; i < dutc_pkg::NUM_CH; i++) begin
        if (load_fall || load_sub[i / dutc_pkg::CH_PER_SUB]) begin
          act_a_mem[i] <= buf_a_mem[i];
          act_b_mem[i] <= buf_b_mem[i];
        end
      end
      if (async_mode && wr_a) begin
        act_a_mem[ch] <= wcode;
      end
      if (async_mode && wr_b) begin
        act_b_mem[ch] <= wcode;
      end else if (async_mode && wr_a && neg_on) begin
        act_b_mem[ch] <= wneg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Toggle state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
      sel_b_reg <= 1'b0;
    end else if (ce) begin
      if (trig_rise) begin
        armed_reg <= 1'b1;
      end
      if (tog_pulse) begin
        sel_b_reg <= ~sel_b_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_code_out <= '0;
    end else if (ce) begin
      for (int i = 0; i < dutc_pkg::NUM_CH; i++) begin
        if (!pins_s.clear_n || clear_sub[i / dutc_pkg::CH_PER_SUB]) begin
          dac_code_out[i*dutc_pkg::CODE_W +: dutc_pkg::CODE_W] <= dutc_pkg::CODE_ZERO;
        end else if (sel_b_reg) begin
          dac_code_out[i*dutc_pkg::CODE_W +: dutc_pkg::CODE_W] <= act_b_mem[i];
        end else begin
          dac_code_out[i*dutc_pkg::CODE_W +: dutc_pkg::CODE_W] <= act_a_mem[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Active register indicator
  // ----------------------------------------------------------------
  dutc_ind_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pulse   (tog_pulse),
    .div     (div_reg),
    .ind     (ind_raw)
  );

  // Only subsystem 0 can enable the pin; other drive fields are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_oe_reg <= 1'b0;
    end else if (ce) begin
      ind_oe_reg <= (ctl_reg[0].drive == dutc_pkg::FIELD_ON);
    end
  end

  assign active_reg_indicator    = ind_raw;
  assign active_reg_indicator_oe = ind_oe_reg;

endmodule : dutc_top

// file: dutc_top_sva.sv
// Checker for the ports of the channel update and toggle control
`timescale 1ns/100ps
module dutc_top_sva (
  // Clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          ce,
  // APB
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [5:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // Pins and outputs
  input wire logic          load_strobe_n,
  input wire logic          clear_n,
  input wire logic          toggle_trigger_pin,
  input wire logic [1151:0] dac_code_out,
  input wire logic          active_reg_indicator,
  input wire logic          active_reg_indicator_oe
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_acc = psel && penable && pready && !pwrite;
  wire wcon   = psel && penable && pready && pwrite && (paddr == 6'h10);

  a_ready_no_wait: assert property (psel && penable && ce |-> pready)
    else $error("access cycle without pready");
  a_reset_codes_zero: assert property ($rose(presetn) |-> dac_code_out == '0)
    else $error("codes not zero after reset");
  a_reset_oe_off: assert property ($rose(presetn) |-> !active_reg_indicator_oe)
    else $error("indicator driven after reset");
  a_oe_from_ctl: assert property ($changed(active_reg_indicator_oe) |-> $past(wcon) || $past(wcon, 2))
    else $error("indicator enable moved without control write");
  a_clear_pin_zero: assert property (!clear_n [*8] |-> dac_code_out == '0)
    else $error("codes not zero in clear");
  a_load_bit_zero: assert property (rd_acc && paddr == 6'h10 && !pslverr |-> !prdata[15] && prdata[2])
    else $error("control read shows load bit");
  a_div_clamped: assert property (rd_acc && paddr == 6'h24 |-> prdata <= 32'h6)
    else $error("divider above six");
  a_code_nibble_zero: assert property (rd_acc && paddr[5:3] == 3'h0 && paddr[1:0] == 2'h0 && !pslverr
    |-> prdata[3:0] == 4'h0 && prdata[31:16] == 16'h0)
    else $error("data read outside code field");
  a_fixed_trigger: assert property ($stable(toggle_trigger_pin) [*8] |-> $stable(active_reg_indicator))
    else $error("indicator moved with trigger fixed");

  c_ctl_write: cover property (wcon);
  c_trigger_fall: cover property ($fell(toggle_trigger_pin));
  c_clear_held: cover property (!clear_n [*8]);
endmodule : dutc_top_sva

bind dutc_top dutc_top_sva u_sva (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .load_strobe_n(load_strobe_n), .clear_n(clear_n), .toggle_trigger_pin(toggle_trigger_pin),
  .dac_code_out(dac_code_out), .active_reg_indicator(active_reg_indicator),
  .active_reg_indicator_oe(active_reg_indicator_oe)
);

// file: dutc_host_model.sv
// Host-side driver of the load, clear and trigger pins
`timescale 1ns/100ps
module dutc_host_model (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // Requested and driven levels
  input  wire dutc_pkg::dutc_pins_t req,
  output dutc_pkg::dutc_pins_t      pins
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // Levels move only after an edge and are held for many cycles, so no pulse is lost in the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= dutc_pkg::PINS_RESET;
    end else begin
      pins <= req;
    end
  end
endmodule : dutc_host_model

// file: tb.sv
// Self-checking bench for the channel update and toggle control
`timescale 1ns/100ps
module tb;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b1;
  logic                 ce = 1'b1;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [5:0]           paddr = 6'h00;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [1151:0]        dac_code_out;
  logic                 ind;
  logic                 ind_oe;
  logic [31:0]          q;
  logic                 err;
  int                   num_errors = 0;
  int                   comparisons = 0;
  int                   cycles = 0;
  dutc_pkg::dutc_pins_t req = dutc_pkg::PINS_RESET;
  dutc_pkg::dutc_pins_t pins;

  always #2.5 pclk = ~pclk;

  dutc_host_model host (.pclk(pclk), .presetn(presetn), .req(req), .pins(pins));
  dutc_top dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .load_strobe_n(pins.load_strobe_n), .clear_n(pins.clear_n), .toggle_trigger_pin(pins.trigger),
    .dac_code_out(dac_code_out), .active_reg_indicator(ind), .active_reg_indicator_oe(ind_oe)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // Starts one edge late so the previous release never shares a time step with a new setup
  task automatic apb(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    apb(1'b0, a, 16'h0000);
    chk(q, e);
  endtask : rd

  // Pin order is load strobe, clear, trigger; ten cycles cover synchroniser and output stage
  task automatic pin(input logic [2:0] v);
    req <= v;
    wt(10);
  endtask : pin

  task automatic pulse;
    pin(3'b111);
    pin(3'b110);
  endtask : pulse

  task automatic rst;
    presetn <= 1'b0;
    wt(20);
    presetn <= 1'b1;
    wt(1);
  endtask : rst

  function automatic logic [11:0] cd(input int c);
    return dac_code_out[c*12+:12];
  endfunction : cd

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      end_sim;
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rst;
    chk(cd(5), 12'h000);
    chk(ind_oe, 1'b0);
    rd(6'h10, 32'h0555);
    apb(1'b1, 6'h24, 16'h0007);
    rd(6'h24, 32'h6);
    apb(1'b1, 6'h24, 16'h0000);
    apb(1'b0, 6'h08, 16'h0000);
    chk(err, 1'b1);
    apb(1'b1, 6'h18, 16'h0005);
    apb(1'b1, 6'h00, 16'h1230);
    rd(6'h00, 32'h1230);
    wt(6);
    chk(cd(5), 12'h000);
    pin(3'b010);
    chk(cd(5), 12'h123);
    apb(1'b1, 6'h00, 16'h4560);
    wt(3);
    chk(cd(5), 12'h456);
    pin(3'b110);
    apb(1'b1, 6'h00, 16'h1110);
    apb(1'b1, 6'h18, 16'h1000);
    apb(1'b1, 6'h00, 16'h0aa0);
    apb(1'b1, 6'h10, 16'h8555);
    wt(3);
    chk(cd(24), 12'h0aa);
    chk(cd(5), 12'h456);
    rd(6'h10, 32'h0555);
    pin(3'b100);
    chk(cd(24), 12'h000);
    apb(1'b1, 6'h00, 16'h0bb0);
    pin(3'b000);
    chk(cd(24), 12'h000);
    pin(3'b110);
    chk(cd(24), 12'h0bb);
    chk(cd(5), 12'h111);
    apb(1'b1, 6'h10, 16'h0525);
    wt(3);
    chk(cd(24), 12'h000);
    chk(cd(5), 12'h111);
    apb(1'b1, 6'h10, 16'h0555);
    wt(3);
    chk(cd(24), 12'h0bb);
    apb(1'b1, 6'h18, 16'h0005);
    apb(1'b1, 6'h10, 16'h0656);
    wt(3);
    chk(ind_oe, 1'b1);
    apb(1'b1, 6'h00, 16'h8000);
    rd(6'h04, 32'h7ff0);
    apb(1'b1, 6'h00, 16'h1000);
    rd(6'h04, 32'hf000);
    apb(1'b1, 6'h04, 16'h0500);
    rd(6'h00, 32'h1000);
    pin(3'b010);
    pin(3'b110);
    chk(cd(5), 12'h100);
    chk(ind, 1'b0);
    pin(3'b111);
    chk(cd(5), 12'h100);
    pin(3'b110);
    chk(cd(5), 12'h050);
    chk(ind, 1'b1);
    pulse;
    chk(cd(5), 12'h100);
    rst;
    chk(cd(5), 12'h000);
    apb(1'b1, 6'h24, 16'h0001);
    rd(6'h24, 32'h1);
    apb(1'b1, 6'h18, 16'h0005);
    apb(1'b1, 6'h04, 16'h0230);
    apb(1'b1, 6'h10, 16'h8656);
    pulse;
    chk(cd(5), 12'h023);
    chk(ind, 1'b0);
    pulse;
    chk(cd(5), 12'h000);
    chk(ind, 1'b1);
    // Armed toggle pulse while the enable is low must leave every state frozen
    ce <= 1'b0;
    pulse;
    chk(cd(5), 12'h000);
    ce <= 1'b1;
    wt(1);
    end_sim;
  end
endmodule : tb
